/* File: cbd_defs.svh */
// constants for the console bus decode and dram control block
// assumes inclusion by cbd_ctrl.sv only; cbd_pkg.sv does not include it
`ifndef CBD_DEFS_SVH
`define CBD_DEFS_SVH
`define CBD_ROM_LAST        16'h17ff
`define CBD_RAM_FIRST       16'h4000
`define CBD_RAM_LAST        16'h7fff
`define CBD_IO_STATUS_LO    8'h00
`define CBD_IO_STATUS_HI    8'h07
`define CBD_IO_CSW_LO       8'h08
`define CBD_IO_CSW_HI       8'h0a
`define CBD_IO_TIMER_HI5    5'h03
`define CBD_IO_READY        8'h20
`define CBD_IO_CMD0_LO      8'h20
`define CBD_IO_CMD0_HI      8'h2f
`define CBD_IO_CMD1_LO      8'h30
`define CBD_IO_CMD1_HI      8'h3f
`define CBD_IO_SER_LO       8'h40
`define CBD_IO_SER_HI       8'h4b
`define CBD_IO_CPU_LO       8'h80
`define CBD_IO_CPU_HI       8'h87
`define CBD_IO_CMD2_LO      8'ha0
`define CBD_IO_CMD2_HI      8'haf
`define CBD_IO_CONS_WR      8'hcc
`define CBD_IO_CONS_RD_Y    8'hec
`define CBD_REFRESH_CTR_RST 7'h00
`endif

/* File: cbd_pkg.sv */
// types for the console bus decode and dram control block
// assumes nothing beyond a systemverilog compiler
package cbd_pkg;
	// processor cycle controls sampled each clock
	typedef struct packed {
		logic       io_cycle;   // i/o rather than memory reference
		logic       rd;         // read strobe
		logic       wr;         // write strobe
		logic [7:0] addr_hi;    // upper address lines
	} cbd_cyc_t;

	// select strobes driven to the devices
	typedef struct packed {
		logic rom_data_mux_select;
		logic sel_status;
		logic control_store_word_write;
		logic sel_timer;
		logic sel_ready;
		logic command_bank0_write;
		logic command_bank1_write;
		logic sel_serial;
		logic sel_cpu_regs;
		logic command_bank2_write;
		logic console_write_load;
		logic console_read_load;
	} cbd_sel_t;

	// dram sequencer states, one-hot
	typedef enum logic [4:0] {
		CBD_IDLE    = 5'b00001,
		CBD_REFRESH = 5'b00010,
		CBD_ROW     = 5'b00100,
		CBD_COL     = 5'b01000,
		CBD_DONE    = 5'b10000
	} cbd_state_t;
endpackage : cbd_pkg

/* File: cbd_ctrl.sv */
// console bus decode, low address latch, rom banking and dram control
// assumes processor signals are synchronous to sys_clk; refresh request
// comes from a divider in another domain and is synchronised here
//
// Behaviour
// - rom 0000-17ff read, ram 4000-7fff
// - io 00-07 status, 08-0a csw, 18-1f timer
// - io read 20 ready; writes 20-2f, 30-3f
// - 40-4b serial, 80-87 cpu read, a0-af write
// - write cc console write, ec from ybus
// - selects from upper address and controls
// - address 12:11 picks rom bank
// - latch low address on address strobe
// - rom mux gates data after address phase
// - odd bits row, even bits column
// - ram address inserts four wait states
// - row strobe, then mux, then column strobe
// - column strobe reads or writes ram byte
// - refresh request edge sets refresh flag
// - refresh drives counter row, row strobe
// - refresh end advances counter by one
// - refresh waits for ram access end
// - pending refresh first, extra wait state
// - refresh waits for serial access too
`timescale 1ns/1ps
`default_nettype none
`include "cbd_defs.svh"
module cbd_ctrl (
	input  wire logic             sys_clk,           // 100 mhz clock
	input  wire logic             rst,               // async reset, high
	input  wire logic             clk_en,            // freezes state when low
	input  wire cbd_pkg::cbd_cyc_t cyc,              // processor controls
	input  wire logic             address_latch_strobe, // cycle start strobe
	input  wire logic [7:0]       buffered_bus_data, // bus data in
	input  wire logic             status_write,      // write from status lines
	input  wire logic             serial_busy,       // serial access active
	input  wire logic             refresh_req_pin,   // 12.8 us request, async
	output cbd_pkg::cbd_sel_t     sel,               // device selects
	output logic [7:0]            latched_addr_lo,   // held low address
	output logic [1:0]            rom_bank,          // rom bank number
	output logic                  rom_mux_input,     // mux input select
	output logic [6:0]            ram_addr,          // multiplexed ram address
	output logic                  row_strobe_ff,     // ram row strobe
	output logic                  column_strobe_ff,  // ram column strobe
	output logic                  ram_write_enable,  // ram write enable
	output logic                  ram_read_drive,    // ram drives the bus
	output logic                  long_cycle,        // wait request
	output logic                  proc_ready,        // processor ready
	output logic                  refresh_cycle_flag // refresh in progress
);
	logic [7:0]          lo_reg;
	logic                start_reg;
	logic                colsel_reg;
	logic [6:0]          rctr_reg;
	logic [3:0]          rsync_reg;
	logic                pend_reg;
	logic                wait_done_reg;
	cbd_pkg::cbd_state_t state_reg;
	logic [15:0]         addr;
	logic                is_ram;
	logic                req_rise;

	// true when value lies in an inclusive range
	function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		in_rng = (v >= lo) && (v <= hi);
	endfunction : in_rng

	assign addr   = {cyc.addr_hi, lo_reg};
	assign is_ram = !cyc.io_cycle && cyc.addr_hi[7:6] == 2'b01;

	// low address captured at cycle start, held all cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lo_reg <= 8'h00;
		end else if (clk_en && address_latch_strobe) begin
			lo_reg <= buffered_bus_data;
		end
	end
	assign latched_addr_lo = lo_reg;
	assign rom_bank        = cyc.addr_hi[4:3];
	assign rom_mux_input   = cyc.addr_hi[5];

	// select decode; io address rides on the upper lines
	always_comb begin
		sel = '0;
		if (!cyc.io_cycle) begin
			sel.rom_data_mux_select = cyc.rd && !address_latch_strobe
				&& addr <= `CBD_ROM_LAST;
		end else begin
			sel.sel_status = cyc.rd && in_rng(cyc.addr_hi, `CBD_IO_STATUS_LO, `CBD_IO_STATUS_HI);
			sel.control_store_word_write = cyc.wr
				&& in_rng(cyc.addr_hi, `CBD_IO_CSW_LO, `CBD_IO_CSW_HI);
			sel.sel_timer = cyc.addr_hi[7:3] == `CBD_IO_TIMER_HI5;
			sel.sel_ready = cyc.rd && cyc.addr_hi == `CBD_IO_READY;
			sel.rom_data_mux_select = sel.sel_ready && !address_latch_strobe;
			sel.command_bank0_write = cyc.wr
				&& in_rng(cyc.addr_hi, `CBD_IO_CMD0_LO, `CBD_IO_CMD0_HI);
			sel.command_bank1_write = cyc.wr
				&& in_rng(cyc.addr_hi, `CBD_IO_CMD1_LO, `CBD_IO_CMD1_HI);
			sel.sel_serial = (cyc.rd || cyc.wr)
				&& in_rng(cyc.addr_hi, `CBD_IO_SER_LO, `CBD_IO_SER_HI);
			sel.sel_cpu_regs = cyc.rd && in_rng(cyc.addr_hi, `CBD_IO_CPU_LO, `CBD_IO_CPU_HI);
			sel.command_bank2_write = cyc.wr
				&& in_rng(cyc.addr_hi, `CBD_IO_CMD2_LO, `CBD_IO_CMD2_HI);
			sel.console_write_load = cyc.wr && cyc.addr_hi == `CBD_IO_CONS_WR;
			sel.console_read_load  = cyc.wr && cyc.addr_hi == `CBD_IO_CONS_RD_Y;
		end
	end

	// request synchroniser; edge seen once stages two and three agree
	// stage four is stage three delayed one clock, so one clean edge counts once
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rsync_reg <= 4'h0;
		end else if (clk_en) begin
			rsync_reg <= {rsync_reg[2:0], refresh_req_pin};
		end
	end
	assign req_rise = rsync_reg[1] && rsync_reg[2] && !rsync_reg[3];

	// pending request; set wins over the clear at the end of the refresh cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pend_reg <= 1'b0;
		end else if (clk_en) begin
			if (req_rise)
				pend_reg <= 1'b1;
			else if (state_reg == cbd_pkg::CBD_REFRESH)
				pend_reg <= 1'b0;
		end
	end

	// cycle-start flag: set by strobe for ram, cleared when access ends
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_reg <= 1'b0;
		end else if (clk_en) begin
			if (address_latch_strobe && is_ram)
				start_reg <= 1'b1;
			else if (state_reg == cbd_pkg::CBD_DONE)
				start_reg <= 1'b0;
		end
	end

	// sequencer; refresh only starts between accesses
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= cbd_pkg::CBD_IDLE;
		end else if (clk_en) begin
			unique case (state_reg)
			cbd_pkg::CBD_IDLE: begin
				if ((pend_reg || req_rise) && !serial_busy)
					state_reg <= cbd_pkg::CBD_REFRESH;
				else if (start_reg)
					state_reg <= cbd_pkg::CBD_ROW;
			end
			cbd_pkg::CBD_REFRESH: state_reg <= cbd_pkg::CBD_IDLE;
			cbd_pkg::CBD_ROW:     state_reg <= cbd_pkg::CBD_COL;
			cbd_pkg::CBD_COL:     state_reg <= cbd_pkg::CBD_DONE;
			cbd_pkg::CBD_DONE:    state_reg <= cbd_pkg::CBD_IDLE;
			default:              state_reg <= cbd_pkg::CBD_IDLE;
			endcase
		end
	end

	// strobe flip-flops; column waits for the mux to leave the row
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			row_strobe_ff    <= 1'b0;
			colsel_reg       <= 1'b0;
			column_strobe_ff <= 1'b0;
		end else if (clk_en) begin
			// row strobe stays up through done so the column strobe never rises alone
			row_strobe_ff    <= state_reg == cbd_pkg::CBD_ROW || state_reg == cbd_pkg::CBD_COL
				|| state_reg == cbd_pkg::CBD_DONE || state_reg == cbd_pkg::CBD_REFRESH;
			colsel_reg       <= state_reg == cbd_pkg::CBD_COL || state_reg == cbd_pkg::CBD_DONE;
			column_strobe_ff <= colsel_reg && state_reg == cbd_pkg::CBD_DONE;
		end
	end
	assign refresh_cycle_flag = state_reg == cbd_pkg::CBD_REFRESH;

	// counter steps at the trailing edge of each refresh
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rctr_reg <= `CBD_REFRESH_CTR_RST;
		end else if (clk_en && state_reg == cbd_pkg::CBD_REFRESH) begin
			rctr_reg <= rctr_reg + 7'h01;
		end
	end

	// address mux; refresh counter overrides the normal path
	always_comb begin
		if (refresh_cycle_flag)
			ram_addr = rctr_reg;
		else if (colsel_reg)
			ram_addr = {addr[12], addr[10], addr[8], addr[6], addr[4], addr[2], addr[0]};
		else
			ram_addr = {addr[13], addr[11], addr[9], addr[7], addr[5], addr[3], addr[1]};
	end

	// wait-state marker: one stretch, refresh adds another
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_done_reg <= 1'b0;
		end else if (clk_en) begin
			wait_done_reg <= state_reg == cbd_pkg::CBD_DONE;
		end
	end
	assign long_cycle       = start_reg && cyc.addr_hi[6] && !wait_done_reg;
	assign proc_ready       = !long_cycle;
	// write enable must outlive the start flag, which clears as the column strobe rises
	assign ram_write_enable = status_write && (start_reg || column_strobe_ff);
	assign ram_read_drive   = column_strobe_ff && cyc.rd;

	a_rfsh_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && refresh_cycle_flag |=> !refresh_cycle_flag || !clk_en)
		else $error("refresh lasted more than one cycle");
	a_rfsh_counter: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && refresh_cycle_flag |=> rctr_reg == $past(rctr_reg) + 7'h01)
		else $error("refresh counter did not advance");
	a_rfsh_not_access: assert property (@(posedge sys_clk) disable iff (rst)
		refresh_cycle_flag |-> !column_strobe_ff)
		else $error("refresh during ram access");
	a_rfsh_serial: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state_reg == cbd_pkg::CBD_IDLE && serial_busy |=> !refresh_cycle_flag)
		else $error("refresh during serial access");
	a_col_after_row: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(column_strobe_ff) |-> row_strobe_ff && colsel_reg)
		else $error("column strobe before row and mux");
	a_wait_state: assert property (@(posedge sys_clk) disable iff (rst)
		is_ram && start_reg && !wait_done_reg |-> !proc_ready)
		else $error("ram access without wait");
	a_timer_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cyc.io_cycle && cyc.addr_hi == 8'h1c |-> sel.sel_timer)
		else $error("timer select missing");
	a_ram_addr_row: assert property (@(posedge sys_clk) disable iff (rst)
		!refresh_cycle_flag && !colsel_reg |-> ram_addr[6] == addr[13] && ram_addr[0] == addr[1])
		else $error("row address wrong");
	a_rom_sel: assert property (@(posedge sys_clk) disable iff (rst)
		!cyc.io_cycle && cyc.addr_hi >= 8'h18 |-> !sel.rom_data_mux_select)
		else $error("rom selected out of range");

	// column side of the ram cycle
	a_col_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && column_strobe_ff |=> !column_strobe_ff)
		else $error("column strobe too long");
	a_ram_read_drv: assert property (@(posedge sys_clk) disable iff (rst)
		column_strobe_ff && cyc.rd |-> ram_read_drive)
		else $error("ram read not driven");
	a_ram_write_en: assert property (@(posedge sys_clk) disable iff (rst)
		column_strobe_ff && status_write |-> ram_write_enable)
		else $error("ram write enable missing");
	a_mux_after_row: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(colsel_reg) |-> row_strobe_ff)
		else $error("column mux before row strobe");
	a_ram_addr_col: assert property (@(posedge sys_clk) disable iff (rst)
		!refresh_cycle_flag && colsel_reg |-> ram_addr[6] == addr[12] && ram_addr[0] == addr[0])
		else $error("column address wrong");

	// refresh path
	a_rfsh_addr: assert property (@(posedge sys_clk) disable iff (rst)
		refresh_cycle_flag |-> ram_addr == rctr_reg)
		else $error("refresh address wrong");
	a_rfsh_ctr_hold: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && !refresh_cycle_flag |=> $stable(rctr_reg))
		else $error("refresh counter moved");
	a_rfsh_on_req: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && req_rise && !serial_busy && state_reg == cbd_pkg::CBD_IDLE |=> refresh_cycle_flag)
		else $error("refresh request ignored");
	a_rfsh_pend_first: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && state_reg == cbd_pkg::CBD_IDLE && pend_reg && !serial_busy |=> refresh_cycle_flag)
		else $error("pending refresh not first");

	// wait state, latch and rom mux and bank
	a_long_not_ready: assert property (@(posedge sys_clk) disable iff (rst)
		long_cycle |-> !proc_ready)
		else $error("ready during long cycle");
	a_wait_ends: assert property (@(posedge sys_clk) disable iff (rst)
		long_cycle |-> ##[1:8] proc_ready)
		else $error("wait state never ended");
	a_latch_load: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && address_latch_strobe |=> latched_addr_lo == $past(buffered_bus_data))
		else $error("low address not latched");
	a_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && !address_latch_strobe |=> $stable(latched_addr_lo))
		else $error("low address not held");
	a_rom_mux_gate: assert property (@(posedge sys_clk) disable iff (rst)
		sel.rom_data_mux_select |-> cyc.rd && !address_latch_strobe)
		else $error("rom mux outside read data phase");
	a_rom_bank_sel: assert property (@(posedge sys_clk) disable iff (rst)
		!cyc.io_cycle |-> rom_bank == cyc.addr_hi[4:3])
		else $error("rom bank wrong");

	// i/o select decode spot checks
	a_status_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cyc.io_cycle && cyc.rd && cyc.addr_hi == 8'h03 |-> sel.sel_status)
		else $error("status select missing");
	a_csw_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cyc.io_cycle && cyc.wr && cyc.addr_hi == 8'h09 |-> sel.control_store_word_write)
		else $error("control store write missing");
	a_ready_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cyc.io_cycle && cyc.rd && cyc.addr_hi == 8'h20 |-> sel.sel_ready)
		else $error("ready select missing");
	a_cmd1_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cyc.io_cycle && cyc.wr && cyc.addr_hi[7:4] == 4'h3 |-> sel.command_bank1_write)
		else $error("command one write missing");
	a_serial_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cyc.io_cycle && cyc.rd && cyc.addr_hi == 8'h40 |-> sel.sel_serial)
		else $error("serial select missing");
	a_cmd2_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cyc.io_cycle && cyc.wr && cyc.addr_hi == 8'ha5 |-> sel.command_bank2_write)
		else $error("command two write missing");
	a_cons_rd_sel: assert property (@(posedge sys_clk) disable iff (rst)
		cyc.io_cycle && cyc.wr && cyc.addr_hi == 8'hec |-> sel.console_read_load)
		else $error("console read load missing");

	// main scenarios
	c_rom_read: cover property (@(posedge sys_clk) sel.rom_data_mux_select);
	c_io_write: cover property (@(posedge sys_clk) sel.command_bank0_write);
	c_refresh: cover property (@(posedge sys_clk) refresh_cycle_flag);
	c_ram_write: cover property (@(posedge sys_clk) column_strobe_ff && ram_write_enable);
	c_rfsh_then_ram: cover property (@(posedge sys_clk) refresh_cycle_flag ##1 row_strobe_ff ##[1:4] column_strobe_ff);
endmodule : cbd_ctrl
`default_nettype wire

/* File: cbd_proc_model.sv */
// processor-side model: one machine cycle per call of run
// assumes the block answers with proc_ready on sys_clk
`timescale 1ns/1ps
`default_nettype none
module cbd_proc_model (
	input  wire logic         sys_clk,              // 100 mhz clock
	input  wire logic         proc_ready,           // low asks for a wait state
	output cbd_pkg::cbd_cyc_t cyc,                  // cycle controls
	output logic              address_latch_strobe, // cycle start
	output logic [7:0]        buffered_bus_data,    // low address, then data
	output logic              status_write          // write from status lines
);
	int n;
	// idle bus at time zero
	initial begin
		cyc = '0;
		address_latch_strobe = 1'b0;
		buffered_bus_data = 8'h00;
		status_write = 1'b0;
	end
	// hold controls only, for the select decode
	task put(input logic [2:0] ctl, input logic [7:0] hi);
		@(posedge sys_clk);
		cyc <= {ctl, hi};
	endtask : put
	// one cycle: address phase, then wait while ready is low
	task run(input logic [2:0] ctl, input logic [15:0] a);
		@(posedge sys_clk);
		cyc <= {ctl, a[15:8]};
		address_latch_strobe <= 1'b1;
		buffered_bus_data <= a[7:0];
		status_write <= ctl[0] & ~ctl[2];
		@(posedge sys_clk);
		address_latch_strobe <= 1'b0;
		buffered_bus_data <= ~a[7:0]; // address gone from the bus
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (proc_ready !== 1'b1 && n < 20);
		cyc <= '0;
		status_write <= 1'b0;
	endtask : run
endmodule : cbd_proc_model
`default_nettype wire

/* File: console_bus_decode_dram_ctrl_bench.sv */
// bench for cbd_ctrl: select decode, ram cycles and refresh
// assumes cbd_pkg and cbd_proc_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module console_bus_decode_dram_ctrl_bench;
	logic sys_clk, rst, serial_busy, refresh_req_pin, alt_s, sw, row_s, col_s, we, rdrv, long_c, rdy, rfl;
	cbd_pkg::cbd_cyc_t cyc;
	cbd_pkg::cbd_sel_t sel;
	logic [11:0] sel_v;
	logic [7:0]  bd, lat, lat_c;
	logic [6:0]  ra, row_a, col_a, ref_a;
	logic [1:0]  bank;
	logic        mux_in, we_c, rd_c;
	int          err_total, cmp_count, n_long, n_row, n_col, n_ref, n_rl;
	// {io,rd,wr}, select bit, expected, port or upper address
	localparam logic [15:0] tab [16] = '{{3'h2,4'hb,1'h1,8'h17}, {3'h2,4'hb,1'h0,8'h18}, {3'h6,4'ha,1'h1,8'h07},
		{3'h6,4'ha,1'h0,8'h08}, {3'h5,4'h9,1'h1,8'h0a}, {3'h5,4'h9,1'h0,8'h0b}, {3'h6,4'h8,1'h1,8'h1d},
		{3'h6,4'h7,1'h1,8'h20}, {3'h5,4'h6,1'h1,8'h2f}, {3'h5,4'h6,1'h0,8'h30}, {3'h5,4'h5,1'h1,8'h3f},
		{3'h6,4'h4,1'h1,8'h4b}, {3'h6,4'h4,1'h0,8'h4c}, {3'h6,4'h3,1'h1,8'h80}, {3'h5,4'h2,1'h1,8'ha0},
		{3'h5,4'h1,1'h1,8'hcc}};
	assign sel_v = sel;
	cbd_ctrl cbd_ctrl_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .cyc(cyc), .address_latch_strobe(alt_s),
		.buffered_bus_data(bd), .status_write(sw), .serial_busy(serial_busy), .refresh_req_pin(refresh_req_pin),
		.sel(sel), .latched_addr_lo(lat), .rom_bank(bank), .rom_mux_input(mux_in), .ram_addr(ra),
		.row_strobe_ff(row_s), .column_strobe_ff(col_s), .ram_write_enable(we), .ram_read_drive(rdrv),
		.long_cycle(long_c), .proc_ready(rdy), .refresh_cycle_flag(rfl));
	cbd_proc_model cbd_proc_model_i (.sys_clk(sys_clk), .proc_ready(rdy), .cyc(cyc), .address_latch_strobe(alt_s),
		.buffered_bus_data(bd), .status_write(sw));
	// free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task stop_test();
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test
	task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	task chk_n(input int got, input int exp, input string m);
		chk(8'(got), 8'(exp), m);
	endtask : chk_n
	// watch one ram cycle; mode 1 ends a serial hold, mode 2 raises a refresh mid-access
	task ram(input logic [2:0] ctl, input logic [15:0] a, input int mode);
		n_long = 0;
		n_row = 0;
		n_col = 0;
		n_ref = 0;
		n_rl = 0;
		fork
			cbd_proc_model_i.run(ctl, a);
			if (mode == 1) @(posedge sys_clk) serial_busy <= 1'b0;
			else if (mode == 2) begin
				repeat (2) @(posedge sys_clk);
				refresh_req_pin <= 1'b1;
			end
			repeat (14) begin
				@(posedge sys_clk);
				#1;
				if (rfl === 1'b1) ref_a = ra;
				if (row_s === 1'b1 && n_row == 0) row_a = ra;
				if (col_s === 1'b1) {col_a, we_c, rd_c, lat_c} = {ra, we, rdrv, lat};
				n_long += (long_c === 1'b1);
				n_row += (row_s === 1'b1);
				n_col += (col_s === 1'b1);
				n_ref += (rfl === 1'b1);
				n_rl += (rfl === 1'b1 && long_c === 1'b1);
			end
		join
		refresh_req_pin <= 1'b0;
	endtask : ram
	// one refresh request edge, then a bounded look for the flag
	task refr(input int exp_seen, input logic [6:0] exp_a);
		n_ref = 0;
		@(posedge sys_clk) refresh_req_pin <= 1'b1;
		repeat (10) begin
			@(posedge sys_clk);
			#1;
			if (rfl === 1'b1) ref_a = ra;
			n_ref += (rfl === 1'b1);
		end
		refresh_req_pin <= 1'b0;
		chk_n(n_ref, exp_seen, "refresh count");
		if (exp_seen == 1) chk(ref_a, exp_a, "refresh row");
	endtask : refr
	// hang guard, far beyond the roughly 125 cycles the tests need
	initial begin
		#50us;
		err_total++;
		stop_test();
	end
	// main sequence
	initial begin
		err_total = 0;
		cmp_count = 0;
		{rst, serial_busy, refresh_req_pin} = 3'h4;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk({row_s, col_s, rfl, long_c, rdy}, 8'h01, "reset state");
		for (int i = 0; i < 16; i++) begin
			cbd_proc_model_i.put(tab[i][15:13], tab[i][7:0]);
			#1;
			chk(sel_v[tab[i][12:9]], tab[i][8], "select");
		end
		cbd_proc_model_i.put(3'h5, 8'hec);
		#1;
		chk(sel_v[0], 8'h01, "console read load");
		cbd_proc_model_i.put(3'h2, 8'h10);
		#1;
		chk({bank, mux_in}, 8'h04, "rom bank");
		ram(3'h2, 16'h5a5a, 0);
		chk_n(n_long, 4, "wait cycles");
		chk_n(n_row * 16 + n_col, 3 * 16 + 1, "strobes");
		chk({row_a, 1'b0}, 8'h66, "row address");
		chk(col_a, 8'h4c, "column address");
		chk(lat_c, 8'h5a, "latched low address");
		chk({we_c, rd_c}, 8'h01, "ram read");
		ram(3'h1, 16'h65c3, 0);
		chk({we_c, rd_c}, 8'h02, "ram write");
		chk(col_a, 8'h39, "write column");
		refr(1, 7'h00);
		refr(1, 7'h01);
		serial_busy <= 1'b1;
		refr(0, 7'h00);
		ram(3'h2, 16'h4001, 1);
		chk_n(n_long * 16 + n_ref, 5 * 16 + 1, "refresh first");
		chk(ref_a, 7'h02, "pending row");
		ram(3'h2, 16'h4000, 2);
		chk_n(n_rl * 16 + n_ref, 0 * 16 + 1, "refresh deferred");
		chk(ref_a, 7'h03, "deferred row");
		stop_test();
	end
endmodule : console_bus_decode_dram_ctrl_bench
`default_nettype wire
